// File: hdl/riops_params.svh
// Offsets, field positions, reset values and timing counts
`ifndef RIOPS_PARAMS_SVH
`define RIOPS_PARAMS_SVH
`define RIOPS_CLK_MHZ 125
`define RIOPS_TICK_MS 1
`define RIOPS_MS_CYCLES (`RIOPS_TICK_MS * `RIOPS_CLK_MHZ * 1000)
`define RIOPS_FILT_MS 4'hA
`define RIOPS_CTRL_OFS 12'h000
`define RIOPS_STAT_OFS 12'h004
`define RIOPS_INPUTS_OFS 12'h008
`define RIOPS_OUTPUTS_OFS 12'h00C
`define RIOPS_PMAP_OFS 12'h040
`define RIOPS_PTBL_OFS 12'h400
`define RIOPS_CTRL_RST 5'h00
`define RIOPS_CTRL_BASE_LSB 0
`define RIOPS_CTRL_EN_BIT 4
`define RIOPS_STAT_PT_LSB 8
`define RIOPS_STAT_PROG_LSB 16
`define RIOPS_STAT_REFUSED_BIT 20
`define RIOPS_STAT_BLOCK_BIT 21
`define RIOPS_PMAP_VALID_BIT 8
`define RIOPS_W1_FORM_BIT 16
`define RIOPS_W1_CLEAN_BIT 17
`define RIOPS_W1_LIFT_BIT 18
`define RIOPS_W1_LAST_BIT 19
`define RIOPS_W2_MS_LSB 16
`endif

// File: hdl/riops_pkg.sv
// Types shared by the program select and sequencing logic
package riops_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_LIFT, ST_COND, ST_CLEAN, ST_SOLDER, ST_HOLD
  } riops_state_type;
  typedef enum logic [1:0] {
    OM_ON, OM_OFF, OM_BLOCK_PULSE, OM_FREE_PULSE
  } riops_out_mode_type;
endpackage : riops_pkg

// File: hdl/riops_point_mem.sv
// Point table memory, one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module riops_point_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [7:0] raddr_a,
  output logic [31:0] rdata_a,
  input wire logic [7:0] raddr_b,
  output logic [31:0] rdata_b
);
  logic [31:0] mem [0:255];

  // No reset on contents; software loads the table before use
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule : riops_point_mem
`default_nettype wire

// File: hdl/riops_program_select.sv
// Program selection, point condition wait and output drive
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Program number uses four consecutive inputs from the chosen base input.
// - Four inputs decode unsigned binary, base is LSB, numbers 1 to 15.
// - Registered number plus start input loads and runs that program.
// - A number maps to one program; reassignment clears the earlier mapping.
// - Each point waits for its input condition before moving on.
// - Pre-cleaning, when enabled, runs after the condition is met.
// - Lift, when enabled, precedes the condition wait.
// - Each condition term tests its input for on or off.
// - Terms combine with grouping, AND and OR into one boolean.
// - Point outputs drive only after soldering and return to start.
// - Outputs offer steady on, steady off, blocking and free pulse.
// - Blocking pulse holds advance until the output has dropped.
// - Free pulse lets the sequence advance while still active.
// - Pulse length is a configurable millisecond value.
`include "riops_params.svh"
module riops_program_select
  import riops_pkg::*;
#(
  parameter int MS_CYCLES = `RIOPS_MS_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [15:0] IN_PINS,
  input wire logic START_PIN,
  output logic [7:0] OUT_PINS,
  output logic LIFT_REQ,
  input wire logic LIFT_DONE,
  output logic CLEAN_REQ,
  input wire logic CLEAN_DONE,
  output logic SOLDER_REQ,
  input wire logic SOLDER_DONE,
  output logic RUNNING,
  output logic [5:0] POINT
);
  // Bus slave state
  logic aphase;
  logic wr_q, wr_d, rdw_q, rdw_d;
  logic [9:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d, rd_mux;
  logic [4:0] ctrl_q, ctrl_d;
  logic map_hit, win_hit;
  logic [31:0] mem_rd_a, mem_rd_b;
  // Time base and input filters
  logic [16:0] tcnt_q, tcnt_d;
  logic tick_q, tick_d;
  logic [16:0] s1_q, s1_d, s2_q, s2_d;
  logic [16:0] filt;
  logic [15:0] in_f;
  logic start_prev_q, start_prev_d, start_rise;
  // Sequencer
  riops_state_type st_q, st_d;
  logic [5:0] pt_q, pt_d;
  logic [3:0] prog_q, prog_d, sel;
  logic [2:0] fidx_q, fidx_d;
  logic [3:0][31:0] pw_q, pw_d;
  logic refused_q, refused_d;
  logic apply, cond_ok, blk_any;
  logic [6:0] pmap [15:0];
  logic [7:0] out_lvl, out_blk;
  logic [15:0] term, e0, e1;

  assign aphase = HSEL & HTRANS[1] & HREADY;
  assign map_hit = ({addr_q[9:4], 6'h00} == `RIOPS_PMAP_OFS);
  // Table spans 0x400 to 0x7FF, so byte bits 11:10 must read 01
  assign win_hit = ({addr_q[9:8], 10'h000} == `RIOPS_PTBL_OFS);
  assign HREADYOUT = ~rdw_q;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_q;

  // Reads take one wait state so the table memory can answer
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (win_hit) begin
      rd_mux = mem_rd_a;
    end else if (map_hit) begin
      rd_mux = {23'h00_0000, pmap[addr_q[3:0]][6], 2'b00,
                pmap[addr_q[3:0]][5:0]};
    end else if ({addr_q, 2'b00} == `RIOPS_CTRL_OFS) begin
      rd_mux = {27'h000_0000, ctrl_q};
    end else if ({addr_q, 2'b00} == `RIOPS_STAT_OFS) begin
      rd_mux = {10'h000, blk_any, refused_q, prog_q, 2'b00, pt_q,
                4'h0, st_q};
    end else if ({addr_q, 2'b00} == `RIOPS_INPUTS_OFS) begin
      rd_mux = {15'h0000, filt};
    end else if ({addr_q, 2'b00} == `RIOPS_OUTPUTS_OFS) begin
      rd_mux = {24'h00_0000, out_lvl};
    end
  end

  always_comb begin
    wr_d = aphase & HWRITE;
    rdw_d = aphase & ~HWRITE;
    addr_d = aphase ? HADDR[11:2] : addr_q;
    rdata_d = rdw_q ? rd_mux : rdata_q;
    ctrl_d = ctrl_q;
    if (wr_q && {addr_q, 2'b00} == `RIOPS_CTRL_OFS) begin
      ctrl_d = HWDATA[4:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_q <= 1'b0;
      rdw_q <= 1'b0;
      addr_q <= 10'h000;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= `RIOPS_CTRL_RST;
    end else begin
      wr_q <= wr_d;
      rdw_q <= rdw_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
    end
  end

  riops_point_mem u_mem (
    .clk(REF_CLK),
    .we(wr_q & win_hit),
    .waddr(addr_q[7:0]),
    .wdata(HWDATA),
    .raddr_a(HADDR[9:2]),
    .rdata_a(mem_rd_a),
    .raddr_b({pt_q, fidx_q[1:0]}),
    .rdata_b(mem_rd_b)
  );

  // Number zero never selects a program
  assign pmap[0] = 7'h00;
  for (genvar n = 1; n < 16; n++) begin : g_map
    logic [6:0] e_q, e_d, nw;
    assign nw = {HWDATA[`RIOPS_PMAP_VALID_BIT], HWDATA[5:0]};
    assign pmap[n] = e_q;
    always_comb begin
      e_d = e_q;
      if (wr_q && map_hit && addr_q[3:0] == 4'(n)) begin
        e_d = nw;
      end else if (wr_q && map_hit && nw[6] && e_q[6] &&
                   e_q[5:0] == nw[5:0]) begin
        e_d = 7'h00;
      end
    end
    always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
        e_q <= 7'h00;
      end else begin
        e_q <= e_d;
      end
    end
  end

  // Millisecond tick
  always_comb begin
    tick_d = (tcnt_q == 17'(MS_CYCLES - 1));
    tcnt_d = tick_d ? 17'h0_0000 : tcnt_q + 17'h0_0001;
    s1_d = {START_PIN, IN_PINS};
    s2_d = s1_q;
    start_prev_d = filt[16];
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tcnt_q <= 17'h0_0000;
      tick_q <= 1'b0;
      s1_q <= 17'h0_0000;
      s2_q <= 17'h0_0000;
      start_prev_q <= 1'b0;
    end else begin
      tcnt_q <= tcnt_d;
      tick_q <= tick_d;
      s1_q <= s1_d;
      s2_q <= s2_d;
      start_prev_q <= start_prev_d;
    end
  end

  for (genvar i = 0; i < 17; i++) begin : g_filt
    logic f_q, f_d;
    logic [3:0] c_q, c_d;
    assign filt[i] = f_q;
    always_comb begin
      f_d = f_q;
      c_d = c_q;
      if (s2_q[i] == f_q) begin
        c_d = 4'h0;
      end else if (tick_q) begin
        c_d = c_q + 4'h1;
        if (c_d == `RIOPS_FILT_MS) begin
          f_d = s2_q[i];
          c_d = 4'h0;
        end
      end
    end
    always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
        f_q <= 1'b0;
        c_q <= 4'h0;
      end else begin
        f_q <= f_d;
        c_q <= c_d;
      end
    end
  end

  assign in_f = filt[15:0];
  assign start_rise = filt[16] & ~start_prev_q;
  assign sel = 4'(in_f >> ctrl_q[`RIOPS_CTRL_BASE_LSB +: 4]);

  assign term = pw_q[0][15:0] & ~(in_f ^ pw_q[0][31:16]);
  assign e0 = pw_q[0][15:0] & ~pw_q[1][15:0];
  assign e1 = pw_q[0][15:0] & pw_q[1][15:0];
  // two groups, AND of ORs or OR of ANDs
  always_comb begin
    if (!pw_q[1][`RIOPS_W1_FORM_BIT]) begin
      cond_ok = (~|e0 | |(term & e0)) & (~|e1 | |(term & e1));
    end else begin
      cond_ok = ~|pw_q[0][15:0] | (|e0 & ((term & e0) == e0)) |
                (|e1 & ((term & e1) == e1));
    end
  end

  assign LIFT_REQ = (st_q == ST_LIFT);
  assign CLEAN_REQ = (st_q == ST_CLEAN);
  assign SOLDER_REQ = (st_q == ST_SOLDER);
  assign RUNNING = (st_q != ST_IDLE);
  assign POINT = pt_q;
  assign blk_any = |out_blk;

  always_comb begin
    st_d = st_q;
    pt_d = pt_q;
    prog_d = prog_q;
    fidx_d = fidx_q;
    pw_d = pw_q;
    refused_d = refused_q;
    apply = 1'b0;
    if (wr_q && {addr_q, 2'b00} == `RIOPS_STAT_OFS &&
        HWDATA[`RIOPS_STAT_REFUSED_BIT]) begin
      refused_d = 1'b0;
    end
    unique case (st_q)
      ST_IDLE: begin
        if (start_rise && ctrl_q[`RIOPS_CTRL_EN_BIT]) begin
          if (pmap[sel][6]) begin
            prog_d = sel;
            pt_d = pmap[sel][5:0];
            fidx_d = 3'h0;
            st_d = ST_FETCH;
          end else begin
            refused_d = 1'b1;
          end
        end
      end
      ST_FETCH: begin
        fidx_d = fidx_q + 3'h1;
        if (fidx_q != 3'h0) begin
          pw_d[fidx_q[1:0] - 2'h1] = mem_rd_b;
        end
        if (fidx_q == 3'h4) begin
          pw_d[3] = mem_rd_b;
          fidx_d = 3'h0;
          st_d = ST_COND;
          if (pw_q[1][`RIOPS_W1_LIFT_BIT]) begin
            st_d = ST_LIFT;
          end
        end
      end
      ST_LIFT: begin
        if (LIFT_DONE) begin
          st_d = ST_COND;
        end
      end
      ST_COND: begin
        if (cond_ok) begin
          st_d = pw_q[1][`RIOPS_W1_CLEAN_BIT] ? ST_CLEAN : ST_SOLDER;
        end
      end
      ST_CLEAN: begin
        if (CLEAN_DONE) begin
          st_d = ST_SOLDER;
        end
      end
      ST_SOLDER: begin
        if (SOLDER_DONE) begin
          st_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!blk_any) begin
          apply = 1'b1;
          pt_d = pt_q + 6'h01;
          st_d = pw_q[1][`RIOPS_W1_LAST_BIT] ? ST_IDLE : ST_FETCH;
        end
      end
    endcase
    // Clearing the enable abandons a running program
    if (!ctrl_q[`RIOPS_CTRL_EN_BIT]) begin
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= ST_IDLE;
      pt_q <= 6'h00;
      prog_q <= 4'h0;
      fidx_q <= 3'h0;
      pw_q <= '0;
      refused_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pt_q <= pt_d;
      prog_q <= prog_d;
      fidx_q <= fidx_d;
      pw_q <= pw_d;
      refused_q <= refused_d;
    end
  end

  for (genvar j = 0; j < 8; j++) begin : g_out
    logic lvl_q, lvl_d, blk_q, blk_d;
    logic [15:0] cnt_q, cnt_d, ms;
    riops_out_mode_type md;
    assign md = riops_out_mode_type'(pw_q[2][2*j +: 2]);
    assign ms = pw_q[2][`RIOPS_W2_MS_LSB +: 16];
    assign out_lvl[j] = lvl_q;
    assign out_blk[j] = blk_q;
    always_comb begin
      lvl_d = lvl_q;
      blk_d = blk_q;
      cnt_d = cnt_q;
      if (cnt_q != 16'h0000 && tick_q) begin
        cnt_d = cnt_q - 16'h0001;
        if (cnt_q == 16'h0001) begin
          lvl_d = 1'b0;
          blk_d = 1'b0;
        end
      end
      if (apply && pw_q[3][j]) begin
        unique case (md)
          OM_ON: begin
            lvl_d = 1'b1;
            blk_d = 1'b0;
            cnt_d = 16'h0000;
          end
          OM_OFF: begin
            lvl_d = 1'b0;
            blk_d = 1'b0;
            cnt_d = 16'h0000;
          end
          OM_BLOCK_PULSE, OM_FREE_PULSE: begin
            lvl_d = (ms != 16'h0000);
            blk_d = (ms != 16'h0000) && (md == OM_BLOCK_PULSE);
            cnt_d = ms;
          end
        endcase
      end
    end
    always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
        lvl_q <= 1'b0;
        blk_q <= 1'b0;
        cnt_q <= 16'h0000;
      end else begin
        lvl_q <= lvl_d;
        blk_q <= blk_d;
        cnt_q <= cnt_d;
      end
    end
  end

  assign OUT_PINS = out_lvl;
endmodule : riops_program_select
`default_nettype wire

// File: testbench/riops_motion_model.sv
// Motion side model answering lift, clean and solder requests
`timescale 1ns/1ps
`default_nettype none
module riops_motion_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic lift_req,
  input wire logic clean_req,
  input wire logic solder_req,
  output logic lift_done,
  output logic clean_done,
  output logic solder_done
);
  logic [5:0] cnt_q, cnt_d;
  logic req, hit;
  assign req = lift_req | clean_req | solder_req;
  // Restart count on answer, so chained requests each wait in full
  always_comb begin
    hit = req && (cnt_q == (slow ? 6'h28 : 6'h02));
    cnt_d = (req && !hit) ? cnt_q + 6'h01 : 6'h00;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 6'h00;
    else cnt_q <= cnt_d;
  end
  assign lift_done = hit & lift_req;
  assign clean_done = hit & clean_req;
  assign solder_done = hit & solder_req;
endmodule : riops_motion_model
`default_nettype wire

// File: testbench/riops_program_select_monitor.sv
// Bus and sequencing checks bound to the program select block
`timescale 1ns/1ps
`default_nettype none
module riops_program_select_monitor #(
  parameter int MS_CYCLES = 20
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [7:0] OUT_PINS,
  input wire logic LIFT_REQ,
  input wire logic LIFT_DONE,
  input wire logic CLEAN_REQ,
  input wire logic CLEAN_DONE,
  input wire logic SOLDER_REQ,
  input wire logic SOLDER_DONE,
  input wire logic RUNNING
);
  logic busy;
  assign busy = LIFT_REQ | CLEAN_REQ | SOLDER_REQ;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  sequence s_taken;
    HSEL && HTRANS[1] && HREADY;
  endsequence
  sequence s_read_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  a_read_wait: assert property (s_taken ##0 !HWRITE |=> s_read_wait)
    else $error("read phase not one wait state");
  a_write_nowait: assert property (s_taken ##0 HWRITE |=> HREADYOUT)
    else $error("write phase stalled");
  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("response not okay");
  a_req_single: assert property (
    $onehot0({LIFT_REQ, CLEAN_REQ, SOLDER_REQ}) && (!busy || RUNNING))
    else $error("motion requests overlap or run while idle");
  a_solder_holds: assert property (
    SOLDER_REQ && !SOLDER_DONE |=> SOLDER_REQ)
    else $error("solder request dropped early");
  a_lift_to_cond: assert property (LIFT_REQ && LIFT_DONE |=> !busy)
    else $error("lift not followed by condition wait");
  a_clean_to_solder: assert property (
    CLEAN_REQ && CLEAN_DONE |=> SOLDER_REQ)
    else $error("clean not followed by solder");
  a_solder_to_hold: assert property (
    SOLDER_REQ && SOLDER_DONE |=> !busy && RUNNING)
    else $error("solder end not followed by hold");
  // Only a hold step may raise an output
  a_out_after: assert property (
    (OUT_PINS & ~$past(OUT_PINS)) != 8'h00
    |-> !$past(busy) && $past(RUNNING))
    else $error("output raised outside hold step");
endmodule : riops_program_select_monitor
bind riops_program_select riops_program_select_monitor #(
  .MS_CYCLES(MS_CYCLES)) u_mon (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .OUT_PINS(OUT_PINS), .LIFT_REQ(LIFT_REQ), .LIFT_DONE(LIFT_DONE),
  .CLEAN_REQ(CLEAN_REQ), .CLEAN_DONE(CLEAN_DONE), .SOLDER_REQ(SOLDER_REQ),
  .SOLDER_DONE(SOLDER_DONE), .RUNNING(RUNNING));
`default_nettype wire

// File: testbench/robot_io_program_select_tb.sv
// Self-checking bench for program select and point sequencing
`timescale 1ns/1ps
`default_nettype none
module robot_io_program_select_tb
  import riops_pkg::*;
;
  localparam int MS = 20;
  localparam int P = 5;
  logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, start = 0, slow = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [15:0] pins = 16'h0;
  logic hrdy, hresp, run, lreq, creq, sreq, ld, cd, sd;
  logic [7:0] outp;
  logic [5:0] pnt;
  logic [3:0] b, num, n2;
  int bad_count = 0, tests_run = 0, pw = 0, pwl = 0;
  always #4 clk = ~clk;
  riops_program_select #(.MS_CYCLES(MS)) dut (
    .REF_CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
    .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .IN_PINS(pins),
    .START_PIN(start), .OUT_PINS(outp), .LIFT_REQ(lreq), .LIFT_DONE(ld),
    .CLEAN_REQ(creq), .CLEAN_DONE(cd), .SOLDER_REQ(sreq),
    .SOLDER_DONE(sd), .RUNNING(run), .POINT(pnt));
  riops_motion_model u_motion (
    .clk(clk), .rst_n(rstn), .slow(slow), .lift_req(lreq),
    .clean_req(creq), .solder_req(sreq), .lift_done(ld),
    .clean_done(cd), .solder_done(sd));
  // Width of the last pulse on output 0
  always @(posedge clk) begin
    pw <= outp[0] ? pw + 1 : 0;
    if (!outp[0] && pw != 0) pwl <= pw;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask : bus
  // Pins settle before start so the capture sees a steady number
  task automatic go(input logic [15:0] p);
    pins <= p;
    cyc(15 * MS);
    start <= 1'b1;
    cyc(30 * MS);
    start <= 1'b0;
    cyc(5 * MS);
    pins <= 16'h0;
  endtask : go
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial begin
    cyc(40000);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    void'($urandom(71011));
    cyc(20);
    rstn <= 1'b1;
    cyc(1);
    chk({hrdy, hresp, run, outp}, {1'b1, 10'h0});
    bus(1'b0, 12'h000, 32'h0); chk(r, 32'h0);
    bus(1'b0, 12'h020, 32'h0); chk(r, 32'h0);
    b = 4'($urandom % 11);
    num = 4'(1 + $urandom % 15);
    n2 = 4'(num % 15 + 1);
    bus(1'b1, 12'h000, {27'h0, 1'b1, b});
    bus(1'b1, 12'h400, 32'h8000_8000);
    bus(1'b1, 12'h404, 32'h0006_0000);
    bus(1'b1, 12'h40C, 32'h3);
    bus(1'b1, 12'h410, 32'h4000);
    bus(1'b1, 12'h414, 32'h0008_0000);
    bus(1'b1, 12'h418, 32'h0);
    bus(1'b1, 12'h41C, 32'h0);
    bus(1'b1, 12'h040 + {6'h0, n2, 2'h0}, 32'h100);
    bus(1'b1, 12'h040 + {6'h0, num, 2'h0}, 32'h100);
    bus(1'b0, 12'h040 + {6'h0, n2, 2'h0}, 32'h0); chk(r, 32'h0);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 12'h408, {16'(P), 12'h0, (i == 1) ? 4'h7 : 4'h2});
      slow <= (i == 1);
      go(16'(num) << b);
      cyc(30 * MS);
      bus(1'b0, 12'h004, 32'h0);
      chk({r[19:16], r[3:0]}, {num, 4'h3});
      pins[15] <= 1'b1;
      do @(posedge clk); while (run !== 1'b0);
      chk(outp, (i == 1) ? 8'h01 : 8'h02);
      chk({26'h0, pnt}, 32'h2);
      cyc(60 * MS);
      pins[15] <= 1'b0;
      chk(pwl >= (P - 1) * MS && pwl <= P * MS + 1, 1);
    end
    for (int k = 0; k < 2; k++) begin
      go((k == 1) ? 16'(n2) << b : 16'h0);
      cyc(20 * MS);
      bus(1'b0, 12'h004, 32'h0);
      chk({r[20], run}, 2'b10);
      bus(1'b1, 12'h004, 32'h0010_0000);
      bus(1'b0, 12'h004, 32'h0); chk(r[20], 1'b0);
    end
    stop_test();
  end
endmodule : robot_io_program_select_tb
`default_nettype wire
